//--- rbs_pkg.sv
// Purpose: Shared constants and types for the reset boot sequencer
// Assumes: 40 MHz system clock
// Notes: Image layout after the signature is fixed by this block
package rbs_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int SPI_HZ = 500_000;
	localparam int I2C_HZ = 400_000;
	localparam logic [7:0] SPI_DIV = 8'(CLK_HZ / SPI_HZ);
	localparam logic [7:0] I2C_DIV = 8'(CLK_HZ / I2C_HZ);
	localparam int SETTLE_MS = 200;
	localparam int SETTLE_CYC_DEF = CLK_HZ / 1000 * SETTLE_MS;
	localparam int PROBE_WAIT_US = 1000;
	localparam int PROBE_WAIT_DEF = CLK_HZ / 1_000_000 * PROBE_WAIT_US;
	localparam logic [23:0] RESET_VECTOR = 24'hFFFF00;
	localparam logic [15:0] EXT_BUS_SELECT_REG_PORT_ADDR = 16'h1C00;
	localparam int PARALLEL_PORT_MODE_LSB = 12;
	localparam logic [2:0] PARALLEL_PORT_MODE_RST = 3'h0;
	localparam logic [2:0] PARALLEL_PORT_MODE_SPI_A = 3'h5;
	localparam logic [2:0] PARALLEL_PORT_MODE_SPI_B = 3'h6;
	localparam logic [6:0] I2C_TARGET = 7'h50;
	localparam logic [2:0] CS_FIRST = 3'h2;
	localparam logic [11:0] MULT_BOOT = 12'h177;
	localparam logic [11:0] MULT_USB_RTC = 12'h465;
	localparam logic [11:0] MULT_USB_EXT = 12'h003;
	localparam logic [1:0] PLL_VS_BOOT = 2'h0;
	localparam logic [1:0] PLL_VO_BOOT = 2'h0;
	localparam logic [15:0] ICR_IDLE_ALL = 16'hFFFE;
	localparam int FLAG_CFG_BIT = 0;
	localparam logic [4:0] PCLK_EMIF = 5'h01;
	localparam logic [4:0] PCLK_SPI = 5'h02;
	localparam logic [4:0] PCLK_I2C = 5'h04;
	localparam logic [4:0] PCLK_CARD = 5'h08;
	localparam logic [4:0] PCLK_USB = 5'h10;
	localparam logic [3:0] STEP_NAND = 4'h4;
	localparam logic [3:0] STEP_SPI = 4'h8;
	localparam logic [3:0] STEP_I2C = 4'hC;
	localparam logic [3:0] STEP_CARD = 4'hD;
	localparam logic [3:0] STEP_USB = 4'hE;
	typedef enum logic [2:0] {SRC_NONE = 3'b000, SRC_NOR = 3'b001, SRC_NAND = 3'b010, SRC_SPI = 3'b011,
		SRC_I2C = 3'b100, SRC_CARD = 3'b101, SRC_USB = 3'b110} rbs_src_t;
	// Feedback value is twice the multiplier less one
	function automatic logic [11:0] rbs_fb(input logic [11:0] m);
		return 12'((m << 1) - 12'h001);
	endfunction
endpackage

//--- rbs_stream_if.sv
// Purpose: Byte stream with valid and ready between sequencer parts
// Assumes: Same clock on both sides
// Notes: Transfer happens when valid and ready are both high
interface rbs_stream_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

//--- rbs_fifo.sv
// Purpose: Byte buffer between link receiver and sequencer
// Assumes: Depth is a power of two
// Notes: Flush empties it in one cycle
module rbs_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic flush,
	rbs_stream_if.snk in_s,
	rbs_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic full;
	logic empty;
	assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty = wr_ptr == rd_ptr;
	assign in_s.ready = !full;
	assign out_s.valid = !empty;
	assign out_s.data = mem[rd_ptr[AW-1:0]];
	always_ff @(posedge clk)
	begin
		if (in_s.valid && !full)
			mem[wr_ptr[AW-1:0]] <= in_s.data;
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else if (flush)
			rd_ptr <= wr_ptr;
		else
		begin
			if (in_s.valid && !full)
				wr_ptr <= wr_ptr + 1'b1;
			if (out_s.ready && !empty)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

//--- rbs_link_rx.sv
// Purpose: Samples the boot memory link and pushes received bytes
// Assumes: Link clock far slower than clk
// Notes: Bytes that meet a held stream are lost; link_ready warns the source
module rbs_link_rx (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic link_clk,
	input wire logic link_frame,
	input wire logic [7:0] link_data,
	rbs_stream_if.src out_s
);
	logic [1:0] clk_sy;
	logic [1:0] frame_sy;
	logic [7:0] data_m;
	logic [7:0] data_s;
	logic clk_prev;
	logic rise;
	assign rise = clk_sy[1] && !clk_prev;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			clk_sy <= 2'h0;
			frame_sy <= 2'h0;
			data_m <= 8'h00;
			data_s <= 8'h00;
			clk_prev <= 1'b0;
		end
		else
		begin
			clk_sy <= {clk_sy[0], link_clk};
			frame_sy <= {frame_sy[0], link_frame};
			data_m <= link_data;
			data_s <= data_m;
			clk_prev <= clk_sy[1];
		end
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			out_s.valid <= 1'b0;
			out_s.data <= 8'h00;
		end
		else if (rise && frame_sy[1] && enable && !(out_s.valid && !out_s.ready))
		begin
			out_s.valid <= 1'b1;
			out_s.data <= data_s;
		end
		else if (out_s.ready || !enable)
			out_s.valid <= 1'b0;
	end
endmodule

//--- rbs_boot_seq.sv
// Purpose: Post-reset boot sequencer: clock setup, source probing, image load, handoff
// Assumes: Boot memories stream bytes on link_clk/link_frame/link_data after probe_req
// Notes: Image after signature: flags, [cfg count, cfg entries], entry, sections
module rbs_boot_seq
	import rbs_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = SETTLE_CYC_DEF,
	parameter int unsigned PROBE_WAIT_CYCLES = PROBE_WAIT_DEF,
	parameter logic [15:0] BOOT_SIG = 16'h0B55,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clock_source_select,
	input wire logic link_clk,
	input wire logic link_frame,
	input wire logic [7:0] link_data,
	output logic link_ready,
	output logic busy,
	output logic cpu_hold,
	output logic [23:0] fetch_addr,
	output logic microproc_mode_bit,
	output logic pll_power,
	output logic pll_bypass,
	output logic [11:0] pll_feedback_value,
	output logic [1:0] pll_secondary_value,
	output logic pll_in_div_en,
	output logic pll_div8_en,
	output logic pll_out_div_en,
	output logic [1:0] pll_output_div_value,
	output logic clock_output_slow_slew,
	output logic clock_output_enable,
	output logic bandgap_trim_apply,
	output logic [15:0] idle_config_register,
	output logic [4:0] periph_clk_en,
	output logic [15:0] ext_bus_select_reg,
	output logic probe_req,
	output logic [2:0] probe_source,
	output logic [2:0] async_chip_selects,
	output logic probe_wide,
	output logic probe_addr24,
	output logic [7:0] serial_clk_div,
	output logic [6:0] i2c_target_addr,
	output logic cfg_wr,
	output logic [15:0] cfg_addr,
	output logic [15:0] cfg_data,
	output logic mem_wr,
	output logic [23:0] mem_addr,
	output logic [7:0] mem_data,
	output logic timer_zero_run,
	output logic [23:0] entry_addr,
	output logic jump
);
	typedef enum logic [4:0] {
		S_FETCH = 5'b00000, S_SLEW = 5'b00001, S_IDLE = 5'b00010, S_PLL = 5'b00011,
		S_TRIM = 5'b00100, S_CLKOFF = 5'b00101, S_PROBE = 5'b00110, S_SIG = 5'b00111,
		S_NEXT = 5'b01000, S_USBPLL = 5'b01001, S_FLAGS = 5'b01010, S_CFGCNT = 5'b01011,
		S_CFG = 5'b01100, S_ENTRY = 5'b01101, S_SECCNT = 5'b01110, S_SECHDR = 5'b01111,
		S_SECDAT = 5'b10000, S_TIMER = 5'b10001, S_SETTLE = 5'b10010, S_JUMP = 5'b10011,
		S_DONE = 5'b10100
	} rbs_state_t;

	rbs_state_t state;
	logic rst_meta;
	logic rst_sync_b;
	logic [1:0] sel_sy;
	logic strap;
	logic [3:0] step;
	logic [2:0] need;
	logic [23:0] acc;
	logic [7:0] cfg_left;
	logic [7:0] sec_left;
	logic [15:0] sec_len;
	logic [23:0] dest;
	logic [31:0] wait_cnt;
	logic [31:0] settle_cnt;
	logic consuming;
	logic take;
	logic [7:0] b;
	logic flush;
	rbs_src_t t_src;
	logic [2:0] t_cs;
	logic t_wide;
	logic t_a24;
	logic [2:0] t_pp;
	logic [4:0] t_pclk;
	logic [7:0] t_div;

	rbs_stream_if #(.W(8)) rx_s ();
	rbs_stream_if #(.W(8)) buf_s ();

	rbs_link_rx u_rx (
		.clk(clk),
		.rst_b(rst_sync_b),
		.enable(probe_req),
		.link_clk(link_clk),
		.link_frame(link_frame),
		.link_data(link_data),
		.out_s(rx_s)
	);

	rbs_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_sync_b),
		.flush(flush),
		.in_s(rx_s),
		.out_s(buf_s)
	);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync_b <= rst_meta;
		end
	end

	// No reset: the strap must be settled in the syncer by the time the first state latches it
	always_ff @(posedge clk)
	begin
		sel_sy <= {sel_sy[0], clock_source_select};
	end

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			link_ready <= 1'b0;
		else
			link_ready <= rx_s.ready;
	end

	// Probe table, one entry per attempt
	always_comb
	begin
		t_src = SRC_USB;
		t_cs = CS_FIRST + {1'b0, step[1:0]};
		t_wide = 1'b0;
		t_a24 = 1'b0;
		t_pp = PARALLEL_PORT_MODE_RST;
		t_pclk = PCLK_USB;
		t_div = 8'h00;
		if (step < STEP_NAND)
		begin
			t_src = SRC_NOR;
			t_wide = 1'b1;
			t_pclk = PCLK_EMIF;
		end
		else if (step < STEP_SPI)
		begin
			t_src = SRC_NAND;
			t_pclk = PCLK_EMIF;
		end
		else if (step < STEP_I2C)
		begin
			t_src = SRC_SPI;
			t_a24 = step[0];
			t_pp = step[1] ? PARALLEL_PORT_MODE_SPI_B : PARALLEL_PORT_MODE_SPI_A;
			t_pclk = PCLK_SPI;
			t_div = SPI_DIV;
		end
		else if (step == STEP_I2C)
		begin
			t_src = SRC_I2C;
			t_pclk = PCLK_I2C;
			t_div = I2C_DIV;
		end
		else if (step == STEP_CARD)
		begin
			t_src = SRC_CARD;
			t_pclk = PCLK_CARD;
		end
	end

	always_comb
	begin
		case (state)
			S_SIG, S_FLAGS, S_CFGCNT, S_CFG, S_ENTRY, S_SECCNT, S_SECHDR, S_SECDAT: consuming = 1'b1;
			default: consuming = 1'b0;
		endcase
	end
	assign buf_s.ready = consuming;
	assign take = consuming && buf_s.valid;
	assign b = buf_s.data;
	// Stale bytes from a failed source must not reach the next probe
	assign flush = state == S_NEXT;

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			state <= S_FETCH;
			strap <= 1'b0;
			step <= 4'h0;
			need <= 3'h0;
			acc <= 24'h000000;
			cfg_left <= 8'h00;
			sec_left <= 8'h00;
			sec_len <= 16'h0000;
			dest <= 24'h000000;
			wait_cnt <= 32'h00000000;
			settle_cnt <= 32'h00000000;
			busy <= 1'b1;
			cpu_hold <= 1'b1;
			fetch_addr <= RESET_VECTOR;
			microproc_mode_bit <= 1'b0;
			pll_power <= 1'b0;
			pll_bypass <= 1'b1;
			pll_feedback_value <= 12'h000;
			pll_secondary_value <= 2'h0;
			pll_in_div_en <= 1'b0;
			pll_div8_en <= 1'b0;
			pll_out_div_en <= 1'b0;
			pll_output_div_value <= 2'h0;
			clock_output_slow_slew <= 1'b0;
			clock_output_enable <= 1'b1;
			bandgap_trim_apply <= 1'b0;
			idle_config_register <= 16'h0000;
			periph_clk_en <= 5'h00;
			ext_bus_select_reg <= 16'h0000;
			probe_req <= 1'b0;
			probe_source <= SRC_NONE;
			async_chip_selects <= 3'h0;
			probe_wide <= 1'b0;
			probe_addr24 <= 1'b0;
			serial_clk_div <= 8'h00;
			i2c_target_addr <= I2C_TARGET;
			cfg_wr <= 1'b0;
			cfg_addr <= 16'h0000;
			cfg_data <= 16'h0000;
			mem_wr <= 1'b0;
			mem_addr <= 24'h000000;
			mem_data <= 8'h00;
			timer_zero_run <= 1'b0;
			entry_addr <= 24'h000000;
			jump <= 1'b0;
		end
		else
		begin
			cfg_wr <= 1'b0;
			mem_wr <= 1'b0;
			jump <= 1'b0;
			if (take)
			begin
				acc <= {acc[15:0], b};
				need <= need - 3'h1;
			end
			case (state)
				S_FETCH:
				begin
					strap <= sel_sy[1];
					state <= S_SLEW;
				end
				S_SLEW:
				begin
					clock_output_slow_slew <= 1'b1;
					state <= S_IDLE;
				end
				S_IDLE:
				begin
					idle_config_register <= ICR_IDLE_ALL;
					state <= S_PLL;
				end
				S_PLL:
				begin
					// Strapped-high reference keeps the bypass path
					if (!strap)
					begin
						pll_power <= 1'b1;
						pll_bypass <= 1'b0;
						pll_feedback_value <= rbs_fb(MULT_BOOT);
						pll_secondary_value <= PLL_VS_BOOT;
						pll_in_div_en <= 1'b0;
						pll_div8_en <= 1'b1;
						pll_out_div_en <= 1'b1;
						pll_output_div_value <= PLL_VO_BOOT;
					end
					state <= S_TRIM;
				end
				S_TRIM:
				begin
					bandgap_trim_apply <= 1'b1;
					state <= S_CLKOFF;
				end
				S_CLKOFF:
				begin
					clock_output_enable <= 1'b0;
					step <= 4'h0;
					state <= S_PROBE;
				end
				S_PROBE:
				begin
					probe_source <= t_src;
					async_chip_selects <= t_cs;
					probe_wide <= t_wide;
					probe_addr24 <= t_a24;
					serial_clk_div <= t_div;
					ext_bus_select_reg[PARALLEL_PORT_MODE_LSB +: 3] <= t_pp;
					periph_clk_en <= t_pclk;
					probe_req <= 1'b1;
					wait_cnt <= 32'h00000000;
					need <= 3'h2;
					state <= S_SIG;
				end
				S_SIG:
				begin
					wait_cnt <= wait_cnt + 32'h00000001;
					if (take && need == 3'h1)
						state <= ({acc[7:0], b} == BOOT_SIG) ? S_FLAGS : S_NEXT;
					else if (wait_cnt == PROBE_WAIT_CYCLES - 1)
						state <= S_NEXT;
				end
				S_NEXT:
				begin
					probe_req <= 1'b0;
					periph_clk_en <= 5'h00;
					if (step == STEP_USB)
						state <= S_PROBE;
					else
					begin
						step <= step + 4'h1;
						state <= (step == STEP_CARD) ? S_USBPLL : S_PROBE;
					end
				end
				S_USBPLL:
				begin
					pll_power <= 1'b1;
					pll_bypass <= 1'b0;
					pll_feedback_value <= rbs_fb(strap ? MULT_USB_EXT : MULT_USB_RTC);
					state <= S_PROBE;
				end
				S_FLAGS:
					if (take)
					begin
						need <= b[FLAG_CFG_BIT] ? 3'h1 : 3'h3;
						state <= b[FLAG_CFG_BIT] ? S_CFGCNT : S_ENTRY;
					end
				S_CFGCNT:
					if (take)
					begin
						cfg_left <= b;
						need <= (b == 8'h00) ? 3'h3 : 3'h4;
						state <= (b == 8'h00) ? S_ENTRY : S_CFG;
					end
				S_CFG:
					if (take && need == 3'h1)
					begin
						cfg_wr <= 1'b1;
						cfg_addr <= acc[23:8];
						cfg_data <= {acc[7:0], b};
						// Bus routing updates on the same edge as the config write
						if (acc[23:8] == EXT_BUS_SELECT_REG_PORT_ADDR)
							ext_bus_select_reg <= {acc[7:0], b};
						cfg_left <= cfg_left - 8'h01;
						need <= (cfg_left == 8'h01) ? 3'h3 : 3'h4;
						state <= (cfg_left == 8'h01) ? S_ENTRY : S_CFG;
					end
				S_ENTRY:
					if (take && need == 3'h1)
					begin
						entry_addr <= {acc[15:0], b};
						need <= 3'h1;
						state <= S_SECCNT;
					end
				S_SECCNT:
					if (take)
					begin
						sec_left <= b;
						need <= 3'h5;
						state <= (b == 8'h00) ? S_TIMER : S_SECHDR;
					end
				S_SECHDR:
					if (take)
					begin
						if (need == 3'h4)
							sec_len <= {acc[7:0], b};
						if (need == 3'h1)
						begin
							dest <= {acc[15:0], b};
							if (sec_len != 16'h0000)
								state <= S_SECDAT;
							else if (sec_left == 8'h01)
								state <= S_TIMER;
							else
							begin
								sec_left <= sec_left - 8'h01;
								need <= 3'h5;
							end
						end
					end
				S_SECDAT:
					if (take)
					begin
						mem_wr <= 1'b1;
						mem_addr <= dest;
						mem_data <= b;
						dest <= dest + 24'h000001;
						sec_len <= sec_len - 16'h0001;
						if (sec_len == 16'h0001)
						begin
							sec_left <= sec_left - 8'h01;
							need <= 3'h5;
							state <= (sec_left == 8'h01) ? S_TIMER : S_SECHDR;
						end
					end
				S_TIMER:
				begin
					probe_req <= 1'b0;
					periph_clk_en <= 5'h00;
					timer_zero_run <= 1'b1;
					settle_cnt <= 32'h00000000;
					state <= S_SETTLE;
				end
				S_SETTLE:
				begin
					settle_cnt <= settle_cnt + 32'h00000001;
					if (settle_cnt == SETTLE_CYCLES - 1)
						state <= S_JUMP;
				end
				S_JUMP:
				begin
					idle_config_register <= ICR_IDLE_ALL;
					periph_clk_en <= 5'h00;
					timer_zero_run <= 1'b0;
					fetch_addr <= entry_addr;
					jump <= 1'b1;
					busy <= 1'b0;
					cpu_hold <= 1'b0;
					state <= S_DONE;
				end
				S_DONE:
					state <= S_DONE;
				default:
					state <= S_FETCH;
			endcase
		end
	end
endmodule

//--- rbs_boot_seq_sva.sv
// Purpose: Port-level checks on the reset boot sequencer
// Assumes: Strap held stable for a whole run between resets
// Notes: Bound into rbs_boot_seq, sees its ports only
module rbs_boot_seq_sva
	import rbs_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = 50
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clock_source_select,
	input wire logic busy,
	input wire logic cpu_hold,
	input wire logic [23:0] fetch_addr,
	input wire logic microproc_mode_bit,
	input wire logic pll_power,
	input wire logic pll_bypass,
	input wire logic [11:0] pll_feedback_value,
	input wire logic [1:0] pll_secondary_value,
	input wire logic pll_in_div_en,
	input wire logic pll_div8_en,
	input wire logic pll_out_div_en,
	input wire logic [1:0] pll_output_div_value,
	input wire logic clock_output_slow_slew,
	input wire logic clock_output_enable,
	input wire logic bandgap_trim_apply,
	input wire logic [15:0] idle_config_register,
	input wire logic [4:0] periph_clk_en,
	input wire logic [15:0] ext_bus_select_reg,
	input wire logic probe_req,
	input wire logic [2:0] probe_source,
	input wire logic [2:0] async_chip_selects,
	input wire logic probe_wide,
	input wire logic [7:0] serial_clk_div,
	input wire logic [6:0] i2c_target_addr,
	input wire logic timer_zero_run,
	input wire logic [23:0] entry_addr,
	input wire logic jump
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	int unsigned tz_cnt;
	// Counts the settling wait so the jump can be tied to its length
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			tz_cnt <= 0;
		else if (timer_zero_run)
			tz_cnt <= tz_cnt + 1;
		else
			tz_cnt <= 0;
	end
	sequence s_wait_end;
		timer_zero_run ##1 !timer_zero_run;
	endsequence
	sequence s_usb_fail;
		probe_req && probe_source == SRC_USB ##1 !probe_req && !timer_zero_run;
	endsequence
	property p_vec;
		busy |-> fetch_addr == RESET_VECTOR && !microproc_mode_bit;
	endproperty
	a_vec: assert property (p_vec) else $error("fetch address or mode wrong while busy");
	property p_pll;
		probe_req && probe_source != SRC_USB |-> (clock_source_select ? pll_bypass : !pll_bypass && pll_power
			&& pll_feedback_value == 12'h2ED && pll_secondary_value == 2'h0 && !pll_in_div_en && pll_div8_en
			&& pll_out_div_en && pll_output_div_value == 2'h0);
	endproperty
	a_pll: assert property (p_pll) else $error("boot clock setup wrong");
	property p_usb;
		probe_req && probe_source == SRC_USB |-> !pll_bypass
			&& pll_feedback_value == (clock_source_select ? 12'h005 : 12'h8C9);
	endproperty
	a_usb: assert property (p_usb) else $error("usb clock setup wrong");
	property p_prep;
		probe_req |-> clock_output_slow_slew && !clock_output_enable && bandgap_trim_apply
			&& idle_config_register == 16'hFFFE;
	endproperty
	a_prep: assert property (p_prep) else $error("preparation incomplete at probe");
	property p_emif;
		probe_req && (probe_source == SRC_NOR || probe_source == SRC_NAND) |->
			async_chip_selects inside {[3'h2:3'h5]} && probe_wide == (probe_source == SRC_NOR);
	endproperty
	a_emif: assert property (p_emif) else $error("parallel probe access wrong");
	property p_spi;
		probe_req && probe_source == SRC_SPI |-> serial_clk_div == 8'h50
			&& ext_bus_select_reg[14:12] inside {3'h5, 3'h6};
	endproperty
	a_spi: assert property (p_spi) else $error("serial probe setup wrong");
	property p_i2c;
		probe_req && probe_source == SRC_I2C |-> serial_clk_div == 8'h64 && i2c_target_addr == 7'h50;
	endproperty
	a_i2c: assert property (p_i2c) else $error("two-wire probe setup wrong");
	property p_pclk;
		!probe_req |-> periph_clk_en == 5'h00;
	endproperty
	a_pclk: assert property (p_pclk) else $error("peripheral clock on outside probe");
	property p_loop;
		s_usb_fail |-> ##[1:2] (probe_req && probe_source == SRC_USB);
	endproperty
	a_loop: assert property (p_loop) else $error("usb probe not repeated");
	property p_settle;
		jump |-> tz_cnt >= SETTLE_CYCLES;
	endproperty
	a_settle: assert property (p_settle) else $error("jump before settling wait");
	property p_hand;
		s_wait_end |-> jump && fetch_addr == entry_addr && periph_clk_en == 5'h00
			&& idle_config_register == 16'hFFFE;
	endproperty
	a_hand: assert property (p_hand) else $error("handoff state wrong");
	property p_busy;
		$fell(busy) |-> jump && $fell(cpu_hold);
	endproperty
	a_busy: assert property (p_busy) else $error("busy dropped without jump");
endmodule
bind rbs_boot_seq rbs_boot_seq_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_rbs_boot_seq_sva (.clk, .rst_b,
	.clock_source_select, .busy, .cpu_hold, .fetch_addr, .microproc_mode_bit, .pll_power, .pll_bypass,
	.pll_feedback_value, .pll_secondary_value, .pll_in_div_en, .pll_div8_en, .pll_out_div_en,
	.pll_output_div_value, .clock_output_slow_slew, .clock_output_enable, .bandgap_trim_apply,
	.idle_config_register, .periph_clk_en, .ext_bus_select_reg, .probe_req, .probe_source,
	.async_chip_selects, .probe_wide, .serial_clk_div, .i2c_target_addr, .timer_zero_run, .entry_addr, .jump);

//--- rbs_mem_model.sv
// Purpose: Boot memory streaming bytes over the link
// Assumes: Link clock of 200 ns, still outside frames
// Notes: Data line shows the inverse of the last byte once released
module rbs_mem_model (
	input wire logic clk,
	input wire logic link_ready,
	output logic link_clk,
	output logic link_frame,
	output logic [7:0] link_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		link_clk = 1'b0;
		link_frame = 1'b0;
		link_data = 8'hA5;
	end
	task automatic send(input logic [7:0] q[$]);
		int i;
		int n;
		@(negedge clk);
		link_frame = 1'b1;
		for (i = 0; i < q.size(); i++)
		begin
			n = 0;
			// Stall while the buffer is full, bytes would be lost
			while (link_ready !== 1'b1 && n < 100)
			begin
				@(negedge clk);
				n++;
			end
			link_data = q[i];
			repeat (4) @(negedge clk);
			link_clk = 1'b1;
			repeat (4) @(negedge clk);
			link_clk = 1'b0;
		end
		link_frame = 1'b0;
		link_data = ~link_data;
	endtask
endmodule

//--- tb_rbs_boot_seq.sv
// Purpose: Self-checking bench for the reset boot sequencer
// Assumes: Short settling and probe waits set by parameter
// Notes: Walks every probe for both straps, then boots from NOR
module tb_rbs_boot_seq;
	import rbs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, clock_source_select, link_clk, link_frame, link_ready, busy, cpu_hold;
	logic microproc_mode_bit, pll_power, pll_bypass, pll_in_div_en, pll_div8_en, pll_out_div_en;
	logic clock_output_slow_slew, clock_output_enable, bandgap_trim_apply, probe_req, probe_wide;
	logic probe_addr24, cfg_wr, mem_wr, timer_zero_run, jump;
	logic [7:0] link_data, serial_clk_div, mem_data;
	logic [23:0] fetch_addr, mem_addr, entry_addr;
	logic [11:0] pll_feedback_value;
	logic [1:0] pll_secondary_value, pll_output_div_value;
	logic [15:0] idle_config_register, ext_bus_select_reg, cfg_addr, cfg_data, cfg_a, cfg_d;
	logic [4:0] periph_clk_en;
	logic [2:0] probe_source, async_chip_selects;
	logic [6:0] i2c_target_addr;
	logic [31:0] mem_q[$];
	int bad_count = 0;
	int checks_done = 0;
	int tz_n = 0;
	rbs_boot_seq #(.SETTLE_CYCLES(50), .PROBE_WAIT_CYCLES(200)) u_rbs_boot_seq (.*);
	rbs_mem_model u_rbs_mem_model (.clk, .link_ready, .link_clk, .link_frame, .link_data);
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		if (cfg_wr === 1'b1)
		begin
			cfg_a <= cfg_addr;
			cfg_d <= cfg_data;
		end
		if (mem_wr === 1'b1)
			mem_q.push_back({mem_addr, mem_data});
		if (timer_zero_run === 1'b1)
			tz_n <= tz_n + 1;
	end
	task automatic final_report();
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic do_reset(input logic s);
		@(negedge clk);
		rst_b = 1'b0;
		clock_source_select = s;
		repeat (10) @(negedge clk);
		check({busy, cpu_hold, microproc_mode_bit, pll_bypass, clock_output_enable, periph_clk_en, fetch_addr},
			{5'h1B, 5'h00, 24'hFFFF00});
		rst_b = 1'b1;
	endtask
	task automatic next_probe();
		int n;
		n = 0;
		while (probe_req !== 1'b0 && n < 500)
		begin
			@(negedge clk);
			n++;
		end
		while (probe_req !== 1'b1 && n < 1000)
		begin
			@(negedge clk);
			n++;
		end
		check(probe_req, 1'b1);
	endtask
	// Nothing answers, so every source fails in turn and USB repeats
	// Model never needs USB oscillator bring-up by software
	task automatic t_walk(input logic s);
		int i;
		logic [2:0] src;
		do_reset(s);
		for (i = 0; i < 16; i++)
		begin
			next_probe();
			src = i < 4 ? SRC_NOR : i < 8 ? SRC_NAND : i < 12 ? SRC_SPI : i == 12 ? SRC_I2C : i == 13 ? SRC_CARD : SRC_USB;
			check(probe_source, src);
			check(periph_clk_en, i < 8 ? 5'h01 : i < 12 ? 5'h02 : i == 12 ? 5'h04 : i == 13 ? 5'h08 : 5'h10);
			if (i == 0 && !s)
				check({pll_power, pll_bypass, pll_in_div_en, pll_div8_en, pll_out_div_en, pll_secondary_value,
					pll_output_div_value, pll_feedback_value}, {5'h13, 4'h0, 12'h2ED});
			if (i == 0 && s)
				check(pll_bypass, 1'b1);
			if (i == 0)
				check({clock_output_slow_slew, clock_output_enable, bandgap_trim_apply, idle_config_register},
					{3'h5, 16'hFFFE});
			if (i < 8)
				check({async_chip_selects, probe_wide}, {3'(2 + i % 4), i < 4});
			if (src == SRC_SPI)
				check({probe_addr24, ext_bus_select_reg[14:12], serial_clk_div}, {i[0], i < 10 ? 3'h5 : 3'h6, 8'h50});
			if (src == SRC_I2C)
				check({i2c_target_addr, serial_clk_div}, {7'h50, 8'h64});
			if (src == SRC_USB)
				check({pll_bypass, pll_feedback_value}, {1'b0, s ? 12'h005 : 12'h8C9});
		end
	endtask
	// Bad signature on the first chip select, full image on the next
	task automatic t_boot();
		int n;
		do_reset(1'b0);
		next_probe();
		u_rbs_mem_model.send('{8'h0B, 8'h54});
		next_probe();
		check({probe_source, async_chip_selects}, {SRC_NOR, 3'h3});
		// Image config only touches the bus select register, never clocks or timer; one two-byte section is loaded
		u_rbs_mem_model.send('{8'h0B, 8'h55, 8'h01, 8'h01, 8'h1C, 8'h00, 8'h60, 8'h00, 8'h01, 8'h23, 8'h45,
			8'h01, 8'h00, 8'h02, 8'h00, 8'h40, 8'h00, 8'hAA, 8'hBB});
		n = 0;
		while (jump !== 1'b1 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		check(jump, 1'b1);
		check(fetch_addr, 24'h012345);
		check(entry_addr, 24'h012345);
		check({busy, cpu_hold, periph_clk_en, idle_config_register}, {7'h00, 16'hFFFE});
		check({cfg_a, cfg_d, ext_bus_select_reg}, {16'h1C00, 16'h6000, 16'h6000});
		check(mem_q.size(), 2);
		check(mem_q[0], {24'h004000, 8'hAA});
		check(mem_q[1], {24'h004001, 8'hBB});
		check(tz_n >= 50, 1'b1);
	endtask
	initial
	begin
		#1000000;
		bad_count++;
		final_report();
	end
	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		clock_source_select = 1'b0;
		t_walk(1'b0);
		t_walk(1'b1);
		t_boot();
		final_report();
	end
endmodule
